// ==== shared/spc_pkg.sv ====
// Package for the serial port pin control block: offsets, fields, reset values
`default_nettype none
package spc_pkg;
  localparam logic [3:0] PIN_CONTROL_OFS = 4'h0;
  localparam logic [3:0] SERIAL_CTRL_OFS = 4'h4;
  localparam logic [3:0] PIN_GPIO_OFS = 4'h8;
  // Pin control field positions
  localparam int RX_CLK_POL_BIT = 0;
  localparam int TX_CLK_POL_BIT = 1;
  localparam int RX_SYNC_POL_BIT = 2;
  localparam int TX_SYNC_POL_BIT = 3;
  localparam int RX_DATA_LVL_BIT = 4;
  localparam int TX_DATA_LVL_BIT = 5;
  localparam int EXT_CLK_LVL_BIT = 6;
  localparam int RSVD7_BIT = 7;
  localparam int RX_CLK_MODE_BIT = 8;
  localparam int TX_CLK_MODE_BIT = 9;
  localparam int RX_GPIO_EN_BIT = 12;
  localparam int TX_GPIO_EN_BIT = 13;
  // Writable bits of the pin control register
  localparam logic [31:0] PIN_CONTROL_WMASK = 32'h0000_3f2f;
  localparam logic [31:0] PIN_CONTROL_RESET = 32'h0000_0000;
  // Serial port control fields: receiver reset_n, transmitter reset_n, loopback
  localparam int RX_ENABLE_BIT = 0;
  localparam int TX_ENABLE_BIT = 1;
  localparam int LOOPBACK_BIT = 2;
  localparam logic [2:0] SERIAL_CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spc_pkg
`default_nettype wire

// ==== design/spc_pin_control.sv ====
// Serial port pin control: clock routing, polarity and pin GPIO behind AXI4-Lite
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`default_nettype none
// Contract
// [RULE1] No loopback: rx clock mode 0 pin is input, 1 pin driven by generator.
// [RULE2] Loopback, rx mode 0: receive clock from transmit clock, rx pin tristated.
// [RULE3] Loopback, rx mode 1: rx clock pin drives the transmit clock.
// [RULE4] Bit 7 reads zero, writes ignored; software writes zero.
// [RULE5] Bit 6 reads sampled external clock pin level in receive GPIO mode.
// [RULE6] Bit 5 sets transmit data pin level in transmit GPIO mode.
// [RULE7] Bit 4 reads sampled receive data pin level in receive GPIO mode.
// [RULE8] Bit 3 transmit sync polarity: 0 active high, 1 active low.
// [RULE9] Bit 2 receive sync polarity: 0 active high, 1 active low.
// [RULE10] Bit 1 transmit clock polarity: 1 inverts the transmit clock.
// [RULE11] Bit 0 receive clock polarity: 0 falling edge sample, 1 rising.
// [RULE12] Receive GPIO mode only under receiver reset; pins become inputs.
// [RULE13] Transmit GPIO mode only under transmitter reset; data pin is output.
// [RULE14] Tx clock mode 0 pin input from outside, 1 driven by generator.
// [RULE15] Polarity applied on pin side so internal signals are active high.
module spc_pin_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gen_clock,
  input wire logic int_tx_sync,
  input wire logic int_tx_data,
  output logic int_rx_clock,
  output logic int_rx_sync,
  output logic int_tx_clock,
  output logic int_rx_data,
  input wire logic tx_clock_pin_i,
  output logic tx_clock_pin_o,
  output logic tx_clock_pin_oe_n,
  input wire logic rx_clock_pin_i,
  output logic rx_clock_pin_o,
  output logic rx_clock_pin_oe_n,
  input wire logic rx_sync_pin,
  output logic tx_sync_pin,
  output logic tx_data_pin,
  input wire logic rx_data_pin,
  input wire logic ext_source_clock_pin
);
  import spc_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {ext_source_clock_pin, rx_data_pin, rx_sync_pin, rx_clock_pin_i,
                  tx_clock_pin_i};
      sync2_q <= sync1_q;
    end
  end
  logic tx_clk_in, rx_clk_in, rx_sync_in, rx_data_in, ext_clk_in;
  assign {ext_clk_in, rx_data_in, rx_sync_in, rx_clk_in, tx_clk_in} = sync2_q;

  // ==========================================================
  // Registers
  logic [31:0] pin_control_q;
  logic [2:0] serial_ctrl_q;
  logic rx_gpio, tx_gpio, loopback;
  assign loopback = serial_ctrl_q[LOOPBACK_BIT];
  assign rx_gpio = pin_control_q[RX_GPIO_EN_BIT] && !serial_ctrl_q[RX_ENABLE_BIT]; // [RULE12]
  assign tx_gpio = pin_control_q[TX_GPIO_EN_BIT] && !serial_ctrl_q[TX_ENABLE_BIT]; // [RULE13]

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  // ==========================================================
  // AXI4-Lite write channel
  logic aw_held_q, w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == PIN_CONTROL_OFS || awaddr_q == SERIAL_CTRL_OFS ||
                        awaddr_q == PIN_GPIO_OFS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read-only bits and bit 7 never stored; bits 4 and 6 read live pin levels in receive GPIO mode, else zero, bit 7 reads zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_control_q <= PIN_CONTROL_RESET;
      serial_ctrl_q <= SERIAL_CTRL_RESET;
    end else if (do_write && awaddr_q == PIN_CONTROL_OFS) begin
      pin_control_q <= merge(pin_control_q, wdata_q, wstrb_q) & PIN_CONTROL_WMASK; // [RULE4]
    end else if (do_write && awaddr_q == SERIAL_CTRL_OFS && wstrb_q[0]) begin
      serial_ctrl_q <= wdata_q[2:0];
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] pin_status;
  always_comb begin
    pin_status = pin_control_q;
    pin_status[RSVD7_BIT] = 1'b0; // [RULE4]
    pin_status[EXT_CLK_LVL_BIT] = rx_gpio ? ext_clk_in : 1'b0; // [RULE5]
    pin_status[RX_DATA_LVL_BIT] = rx_gpio ? rx_data_in : 1'b0; // [RULE7]
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        unique case (s_axi_araddr)
          PIN_CONTROL_OFS: s_axi_rdata <= pin_status;
          SERIAL_CTRL_OFS: s_axi_rdata <= {29'h0000_0000, serial_ctrl_q};
          PIN_GPIO_OFS: s_axi_rdata <= {30'h0000_0000, rx_gpio, tx_gpio};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Clock routing and polarity
  logic tx_clk_src, rx_clk_src;
  // Pin clock modes outside loopback: input from outside when 0, generator when 1
  assign tx_clk_src = pin_control_q[TX_CLK_MODE_BIT] ? gen_clock : tx_clk_in; // [RULE14]
  always_comb begin
    if (loopback) begin
      rx_clk_src = tx_clk_src; // [RULE2] [RULE3]
    end else if (pin_control_q[RX_CLK_MODE_BIT]) begin
      rx_clk_src = gen_clock; // [RULE1]
    end else begin
      rx_clk_src = rx_clk_in; // [RULE1]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_clock_pin_o <= 1'b0;
      tx_clock_pin_oe_n <= 1'b1;
      rx_clock_pin_o <= 1'b0;
      rx_clock_pin_oe_n <= 1'b1;
    end else begin
      tx_clock_pin_o <= gen_clock ^ pin_control_q[TX_CLK_POL_BIT]; // [RULE10] [RULE15]
      tx_clock_pin_oe_n <= !pin_control_q[TX_CLK_MODE_BIT] || tx_gpio; // [RULE14]
      rx_clock_pin_o <= rx_clk_src ^ !pin_control_q[RX_CLK_POL_BIT]; // [RULE11] [RULE15]
      // Rx mode 1 drives pin (generator or, in loopback, tx clock) except in receive GPIO mode; mode 0 tristates
      rx_clock_pin_oe_n <= !pin_control_q[RX_CLK_MODE_BIT] || rx_gpio; // [RULE1] [RULE2] [RULE3]
    end
  end

  // Internal clocks normalised so internal logic acts on the rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_tx_clock <= 1'b0;
      int_rx_clock <= 1'b0;
      int_rx_sync <= 1'b0;
      int_rx_data <= 1'b0;
    end else begin
      int_tx_clock <= tx_clk_src ^ pin_control_q[TX_CLK_POL_BIT]; // [RULE10]
      int_rx_clock <= rx_clk_src ^ !pin_control_q[RX_CLK_POL_BIT]; // [RULE11]
      int_rx_sync <= !rx_gpio && (rx_sync_in ^ pin_control_q[RX_SYNC_POL_BIT]); // [RULE9] [RULE15]
      int_rx_data <= !rx_gpio && rx_data_in; // [RULE12]
    end
  end

  // ==========================================================
  // Transmit pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_sync_pin <= 1'b0;
      tx_data_pin <= 1'b0;
    end else begin
      tx_sync_pin <= int_tx_sync ^ pin_control_q[TX_SYNC_POL_BIT]; // [RULE8] [RULE15]
      tx_data_pin <= tx_gpio ? pin_control_q[TX_DATA_LVL_BIT] : int_tx_data; // [RULE6] [RULE13]
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rsvd_bit_zero_a: assert property (s_axi_rvalid && $past(s_axi_araddr) == PIN_CONTROL_OFS
      && $rose(s_axi_rvalid) |-> !s_axi_rdata[RSVD7_BIT]) // [RULE4]
    else $error("reserved bit 7 read nonzero");
  rx_pin_tristate_a: assert property (loopback && !pin_control_q[RX_CLK_MODE_BIT]
      ##1 loopback && !pin_control_q[RX_CLK_MODE_BIT] |-> rx_clock_pin_oe_n) // [RULE2]
    else $error("rx clock pin driven in loopback mode 0");
  rx_pin_loop_a: assert property (loopback && pin_control_q[RX_CLK_MODE_BIT] && !rx_gpio
      |=> rx_clock_pin_o == ($past(tx_clk_src) ^ !$past(pin_control_q[RX_CLK_POL_BIT]))) // [RULE3]
    else $error("rx clock pin not carrying transmit clock");
  rx_pin_gen_a: assert property (!loopback && pin_control_q[RX_CLK_MODE_BIT] && !rx_gpio
      |=> !rx_clock_pin_oe_n) // [RULE1]
    else $error("rx clock pin not driven in mode 1");
  tx_pin_mode_a: assert property (!pin_control_q[TX_CLK_MODE_BIT] |=> tx_clock_pin_oe_n) // [RULE14]
    else $error("tx clock pin driven in input mode");
  tx_data_gpio_a: assert property (tx_gpio ##1 tx_gpio |-> tx_data_pin
      == $past(pin_control_q[TX_DATA_LVL_BIT])) // [RULE6]
    else $error("tx data pin not at gpio level");
  tx_gpio_gate_a: assert property (serial_ctrl_q[TX_ENABLE_BIT] |-> !tx_gpio) // [RULE13]
    else $error("tx gpio active while transmitter enabled");
  rx_sync_pol_a: assert property (!rx_gpio |=> int_rx_sync
      == ($past(rx_sync_in) ^ $past(pin_control_q[RX_SYNC_POL_BIT]))) // [RULE9]
    else $error("rx sync polarity wrong");
  tx_sync_pol_a: assert property (1'b1 |=> tx_sync_pin
      == ($past(int_tx_sync) ^ $past(pin_control_q[TX_SYNC_POL_BIT]))) // [RULE8]
    else $error("tx sync polarity wrong");
  rx_lvl_status_a: assert property (!rx_gpio |-> !pin_status[RX_DATA_LVL_BIT]
      && !pin_status[EXT_CLK_LVL_BIT]) // [RULE5] [RULE7]
    else $error("pin level status shown outside gpio mode");

  rx_gpio_gate_a: assert property (serial_ctrl_q[RX_ENABLE_BIT] |-> !rx_gpio) // [RULE12]
    else $error("rx gpio active while receiver enabled");
  rx_data_gpio_a: assert property (rx_gpio |=> !int_rx_data) // [RULE12]
    else $error("rx data passed inward in gpio mode");
  rx_data_path_a: assert property (!rx_gpio |=> int_rx_data == $past(rx_data_in)) // [RULE12]
    else $error("rx data path broken");
  tx_data_path_a: assert property (!tx_gpio |=> tx_data_pin == $past(int_tx_data)) // [RULE13]
    else $error("tx data pin not carrying serial data");
  rx_oe_gpio_a: assert property (rx_gpio |=> rx_clock_pin_oe_n) // [RULE12]
    else $error("rx clock pin driven in gpio mode");
  tx_oe_gpio_a: assert property (tx_gpio |=> tx_clock_pin_oe_n) // [RULE13]
    else $error("tx clock pin driven in gpio mode");
  rx_pin_input_a: assert property (!loopback && !pin_control_q[RX_CLK_MODE_BIT] // [RULE1]
      |=> rx_clock_pin_oe_n)
    else $error("rx clock pin driven in input mode");

  // Tx clock pin output carries the generator after the polarity flip
  tx_pin_drive_a: assert property (pin_control_q[TX_CLK_MODE_BIT] && !tx_gpio // [RULE14]
      |=> !tx_clock_pin_oe_n && tx_clock_pin_o
      == ($past(gen_clock) ^ $past(pin_control_q[TX_CLK_POL_BIT])))
    else $error("tx clock pin not driven by generator");
  int_tx_clk_a: assert property (1'b1 |=> int_tx_clock // [RULE10]
      == ($past(tx_clk_src) ^ $past(pin_control_q[TX_CLK_POL_BIT])))
    else $error("internal tx clock polarity wrong");
  int_rx_clk_a: assert property (1'b1 |=> int_rx_clock // [RULE11]
      == ($past(rx_clk_src) ^ !$past(pin_control_q[RX_CLK_POL_BIT])))
    else $error("internal rx clock polarity wrong");
  rx_lvl_live_a: assert property (rx_gpio |-> pin_status[RX_DATA_LVL_BIT] == rx_data_in // [RULE7]
      && pin_status[EXT_CLK_LVL_BIT] == ext_clk_in)
    else $error("pin level status not live in gpio mode");
  wmask_hold_a: assert property ((pin_control_q & ~PIN_CONTROL_WMASK) == 32'h0000_0000) // [RULE4]
    else $error("unwritable pin control bit stored");

  // ==========================================================
  // Bus handshake checks
  // A response must stand until taken, or the master loses it
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped before taken");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");
  awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held too long");
  arready_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held too long");

  // ==========================================================
  // Scenario covers
  wr_resp_c: cover property (s_axi_bvalid && s_axi_bready);
  lb_rx_input_c: cover property (loopback && !pin_control_q[RX_CLK_MODE_BIT]);
  rd_resp_c: cover property (s_axi_rvalid && s_axi_rready);
  loop_c: cover property (loopback && pin_control_q[RX_CLK_MODE_BIT]);
  gpio_c: cover property (rx_gpio && tx_gpio);
endmodule : spc_pin_control
`default_nettype wire

// ==== bench/spc_codec_model.sv ====
// Behavioural model of the external codec facing the serial port pins
`default_nettype none
module spc_codec_model (
  input wire logic frame_on,
  input wire logic data_lvl,
  input wire logic sync_lvl,
  input wire logic aux_lvl,
  output logic link_clk,
  output logic rx_data_pin,
  output logic rx_sync_pin,
  output logic ext_source_clock_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Link clock
  // Runs only inside frames and rests low, so no stale edge is seen
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever begin
      #62.5;
      link_clk = frame_on ? ~link_clk : 1'b0;
    end
  end
  // Codec always drives its outputs, so the pins are never left floating
  assign rx_data_pin = data_lvl;
  assign rx_sync_pin = sync_lvl;
  assign ext_source_clock_pin = aux_lvl;
endmodule : spc_codec_model
`default_nettype wire

// ==== bench/tb_spc_pin_control.sv ====
// Self-checking testbench for the serial port pin control block
`default_nettype none
module tb_spc_pin_control;
  timeunit 1ns;
  timeprecision 100ps;
  import spc_pkg::*;
  // ==========================================================
  // Signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, gen_clock = 0, int_tx_sync = 0, int_tx_data = 0, frame_on = 0;
  logic data_lvl = 0, sync_lvl = 0, aux_lvl = 0, prev = 0;
  logic int_rx_clock, int_rx_sync, int_tx_clock, int_rx_data, tx_clock_pin_o;
  logic tx_clock_pin_oe_n, rx_clock_pin_o, rx_clock_pin_oe_n, tx_sync_pin, tx_data_pin;
  logic link_clk, rx_sync_pin, rx_data_pin, ext_source_clock_pin;
  // Whoever enables its driver owns the clock wire; otherwise the codec does
  wire logic tx_clock_pin_i = tx_clock_pin_oe_n ? link_clk : tx_clock_pin_o;
  wire logic rx_clock_pin_i = rx_clock_pin_oe_n ? link_clk : rx_clock_pin_o;
  int mismatches = 0, n_checks = 0, cyc = 0, n = 0;
  always #5 aclk = ~aclk;
  spc_pin_control spc_pin_control_inst (.*);
  spc_codec_model spc_codec_model_inst (.frame_on(frame_on), .data_lvl(data_lvl),
    .sync_lvl(sync_lvl), .aux_lvl(aux_lvl), .link_clk(link_clk), .rx_data_pin(rx_data_pin),
    .rx_sync_pin(rx_sync_pin), .ext_source_clock_pin(ext_source_clock_pin));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    rsp = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd
  task automatic settle;
    repeat (5) @(posedge aclk);
  endtask : settle
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // Whole run needs a few hundred cycles; the ceiling only catches a hang
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  // ==========================================================
  // Sequence
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PIN_CONTROL_OFS);
    chk(rdat, PIN_CONTROL_RESET);
    rd(4'hc);
    chk(rsp, RESP_SLVERR);
    chk(rdat, 32'h0);
    // Receiver and transmitter still in reset, so both GPIO modes take hold
    wr(PIN_CONTROL_OFS, 32'hffff_ff7f);
    chk(rsp, RESP_OKAY);
    rd(PIN_CONTROL_OFS);
    chk(rdat, 32'h0000_3f2f);
    data_lvl <= 1'b1;
    aux_lvl <= 1'b1;
    settle();
    rd(PIN_CONTROL_OFS);
    chk(rdat, 32'h0000_3f7f);
    rd(PIN_GPIO_OFS);
    chk(rdat, 32'h3);
    chk(rx_clock_pin_oe_n, 1'b1);
    chk(tx_data_pin, 1'b1);
    data_lvl <= 1'b0;
    wr(PIN_CONTROL_OFS, 32'h0000_3000);
    settle();
    chk(tx_data_pin, 1'b0);
    rd(PIN_CONTROL_OFS);
    chk(rdat, 32'h0000_3040);
    wr(SERIAL_CTRL_OFS, 32'h3);
    rd(PIN_GPIO_OFS);
    chk(rdat, 32'h0);
    rd(PIN_CONTROL_OFS);
    chk(rdat, 32'h0000_3000);
    // Loopback, rx clock mode and generator level in every combination
    for (int i = 0; i < 8; i++) begin
      gen_clock <= i[0];
      wr(SERIAL_CTRL_OFS, {29'h0, i[2], 2'b11});
      wr(PIN_CONTROL_OFS, {22'h0, 1'b1, i[1], 8'h01});
      settle();
      chk(rx_clock_pin_oe_n, !i[1]);
      chk(tx_clock_pin_oe_n, 1'b0);
      chk(tx_clock_pin_o, i[0]);
      if (i[1]) chk(rx_clock_pin_o, i[0]);
      else chk(int_rx_clock, i[2] & i[0]);
    end
    wr(SERIAL_CTRL_OFS, 32'h3);
    gen_clock <= 1'b1;
    int_tx_sync <= 1'b1;
    int_tx_data <= 1'b1;
    data_lvl <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      wr(PIN_CONTROL_OFS, {22'h0, 2'b10, 4'h0, p[1], p[0], p[1], p[0]});
      settle();
      chk(tx_sync_pin, !p[1]);
      chk(int_rx_sync, p[0]);
      chk(tx_clock_pin_o, !p[1]);
      chk(int_tx_clock, !p[1]);
      chk(int_rx_clock, !p[0]);
      chk(tx_data_pin, 1'b1);
      chk(int_rx_data, 1'b1);
    end
    // 2000 ns of link clock at 125 ns; phase is free, so allow one edge of slack
    frame_on <= 1'b1;
    repeat (200) begin
      @(posedge aclk);
      if (int_rx_clock && !prev) n++;
      prev = int_rx_clock;
    end
    chk(n >= 15 && n <= 17, 1'b1);
    frame_on <= 1'b0;
    stop_test();
  end
endmodule : tb_spc_pin_control
`default_nettype wire
